// ### pgscs_clock_mux.sv
// Glitch-free two-source slow clock selector
`timescale 1ns/1ps
module pgscs_clock_mux (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic sel_internal,
    input  wire logic ext_level,
    input  wire logic int_level,
    output logic      slow_out
);
    // ------------------------------------------------------------
    // Break-before-make handover
    // ------------------------------------------------------------
    // A source is released only while its level is low and taken only on
    // its falling edge, so the first low phase after a handover is whole.
    logic ext_en_reg;
    logic int_en_reg;
    logic ext_prev_reg;
    logic int_prev_reg;

    always_ff @(posedge clock) begin
        if (srst) begin
            ext_prev_reg <= 1'b0;
            int_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_level;
            int_prev_reg <= int_level;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ext_en_reg <= 1'b0;
            int_en_reg <= 1'b0;
        end else begin
            if (!ext_level && (sel_internal || int_en_reg)) begin
                ext_en_reg <= 1'b0;
            end else if (!ext_level && ext_prev_reg) begin
                ext_en_reg <= 1'b1;
            end
            if (!int_level && (!sel_internal || ext_en_reg)) begin
                int_en_reg <= 1'b0;
            end else if (!int_level && int_prev_reg) begin
                int_en_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            slow_out <= 1'b0;
        end else begin
            slow_out <= (ext_en_reg && ext_level) || (int_en_reg && int_level);
        end
    end

    a_never_both : assert property (@(posedge clock) disable iff (srst)
        !(ext_en_reg && int_en_reg))
        else $error("both slow clock sources enabled");

    a_enable_low_edge : assert property (@(posedge clock) disable iff (srst)
        $changed(int_en_reg) |-> !$past(int_level))
        else $error("internal source switched while high");

    a_ext_low_edge : assert property (@(posedge clock) disable iff (srst)
        $changed(ext_en_reg) |-> !$past(ext_level))
        else $error("external source switched while high");

    a_take_on_fall : assert property (@(posedge clock) disable iff (srst)
        $rose(int_en_reg) |-> $past(int_level, 2))
        else $error("internal source taken away from its falling edge");
endmodule

// ### pgscs_partner.sv
// Model of the external slow clock source wired to the slow clock pin, toggling every HALF_NS (37 ns by default)
`timescale 1ns/1ps
module pgscs_partner #(
    parameter int HALF_NS = 37
) (
    input  wire logic connected,
    output logic      pin
);
    // Unfitted source means a grounded pin, never a floating one
    initial begin
        pin = 1'b0;
        forever begin
            #(HALF_NS);
            pin = connected ? ~pin : 1'b0;
        end
    end
endmodule

// ### pgscs_pkg.sv
// Package: constants for the power-gate and slow-clock-select block
package pgscs_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] SLOW_CLOCK_SOURCE_CFG_OFS = 8'hf0;
    localparam int         SLOW_CLOCK_ABSENT_BIT     = 0;
    localparam logic       SLOW_CLOCK_ABSENT_RST     = 1'b0;
    localparam logic [7:0] CFG_RESERVED_READ         = 8'h00;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int FAST_CLOCK_HZ  = 100_000_000;
    localparam int SLOW_CLOCK_HZ  = 32_768;
    // Half period of the internal slow clock in fast cycles, rounded down
    localparam int SLOW_HALF_CYC  = FAST_CLOCK_HZ / (2 * SLOW_CLOCK_HZ);
    localparam int SYNC_STAGES    = 2;
endpackage

// ### pgscs_top.sv
// Power-good host gating, trickle reset and slow clock source selection
// ------------------------------------------------------------
// How it works
// - Internal supply-good and host enable follow main supply above threshold only.
// - With supply-good low, host reads and writes are ignored, not decoded.
// - Wake output, slow clock pin and wake inputs stay live on trickle supply.
// - Infrared transmit and indicator outputs keep running without supply-good.
// - Supply-good low disables the infrared half-duplex timeout.
// - Trickle power-on reset initialises infrared and wake-event logic.
// - Slow-clock-absent flag is bit 0 at 0xf0, cleared by trickle reset.
// - Flag 0 means external clock connected (default), 1 means pin grounded.
// - Flag 0 picks external slow clock, 1 picks divided internal clock.
// - Internal clock runs only with main supply; dead on trickle alone.
// ------------------------------------------------------------
`timescale 1ns/1ps
module pgscs_top #(
    parameter int HALF_CYC = pgscs_pkg::SLOW_HALF_CYC
) (
    input  wire logic       CLOCK,
    input  wire logic       SRST,
    input  wire logic       TRICKLE_POR,
    input  wire logic       MAIN_SUPPLY_ABOVE,
    input  wire logic       SLOW_CLOCK_PIN,
    input  wire logic       HOST_RD,
    input  wire logic       HOST_WR,
    input  wire logic [7:0] HOST_ADDR,
    input  wire logic [7:0] HOST_WDATA,
    output logic      [7:0] HOST_RDATA,
    output logic            HOST_ACK,
    output logic            SUPPLY_GOOD_INTERNAL,
    output logic            HOST_IF_ENABLE,
    output logic            WAKE_LOGIC_RESET,
    output logic            IR_TIMEOUT_ENABLE,
    output logic            STANDBY_KEEP_ALIVE,
    output logic            SLOW_CLOCK_ABSENT,
    output logic            SLOW_CLOCK_OUT,
    output logic            SLOW_CLOCK_RUNNING
);
    // Divider needs at least one fast cycle per half period
    if (HALF_CYC < 1) begin : g_bad_half
        $error("HALF_CYC must be at least 1");
    end

    // ------------------------------------------------------------
    // Synchronisers for pin-side levels
    // ------------------------------------------------------------
    logic [1:0] good_sync_reg;
    logic [1:0] por_sync_reg;
    logic [1:0] pin_sync_reg;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            good_sync_reg <= 2'h0;
            por_sync_reg  <= 2'h3;
            pin_sync_reg  <= 2'h0;
        end else begin
            good_sync_reg <= {good_sync_reg[0], MAIN_SUPPLY_ABOVE};
            por_sync_reg  <= {por_sync_reg[0], TRICKLE_POR};
            pin_sync_reg  <= {pin_sync_reg[0], SLOW_CLOCK_PIN};
        end
    end

    logic supply_good;
    logic trickle_rst;
    logic ext_level;
    assign supply_good = good_sync_reg[1];
    assign trickle_rst = por_sync_reg[1];
    assign ext_level   = pin_sync_reg[1];

    // ------------------------------------------------------------
    // Supply-good derived controls
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            SUPPLY_GOOD_INTERNAL <= 1'b0;
            HOST_IF_ENABLE       <= 1'b0;
            IR_TIMEOUT_ENABLE    <= 1'b0;
        end else begin
            SUPPLY_GOOD_INTERNAL <= supply_good;
            HOST_IF_ENABLE       <= supply_good;
            IR_TIMEOUT_ENABLE    <= supply_good;
        end
    end

    // Wake reset and standby keep-alive are never gated by supply-good; the infrared timeout enable is
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            WAKE_LOGIC_RESET   <= 1'b1;
            STANDBY_KEEP_ALIVE <= 1'b0;
        end else begin
            WAKE_LOGIC_RESET   <= trickle_rst;
            STANDBY_KEEP_ALIVE <= !trickle_rst;
        end
    end

    // ------------------------------------------------------------
    // Host register access
    // ------------------------------------------------------------
    // One mapped offset; any other address reads as reserved
    function automatic logic cfg_hit(input logic [7:0] addr);
        return addr == pgscs_pkg::SLOW_CLOCK_SOURCE_CFG_OFS;
    endfunction

    logic host_live;
    assign host_live = SUPPLY_GOOD_INTERNAL && !WAKE_LOGIC_RESET;

    // Register lives on the trickle supply: only SRST, trickle reset and a host write of 0 clear it
    always_ff @(posedge CLOCK) begin
        if (SRST || trickle_rst) begin
            SLOW_CLOCK_ABSENT <= pgscs_pkg::SLOW_CLOCK_ABSENT_RST;
        end else if (host_live && HOST_WR && cfg_hit(HOST_ADDR)) begin
            SLOW_CLOCK_ABSENT <= HOST_WDATA[pgscs_pkg::SLOW_CLOCK_ABSENT_BIT];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            HOST_RDATA <= 8'h00;
            HOST_ACK   <= 1'b0;
        end else begin
            HOST_ACK   <= host_live && (HOST_RD || HOST_WR);
            HOST_RDATA <= pgscs_pkg::CFG_RESERVED_READ;
            if (host_live && HOST_RD && cfg_hit(HOST_ADDR)) begin
                HOST_RDATA[pgscs_pkg::SLOW_CLOCK_ABSENT_BIT] <= SLOW_CLOCK_ABSENT;
            end
        end
    end

    // ------------------------------------------------------------
    // Internal slow clock, divided from the fast clock
    // ------------------------------------------------------------
    // Only runs with main supply: the fast clock is gone on trickle.
    localparam int CW = $clog2(HALF_CYC + 1);
    logic [CW-1:0] div_reg;
    logic          int_level_reg;

    always_ff @(posedge CLOCK) begin
        if (SRST || !supply_good) begin
            div_reg       <= '0;
            int_level_reg <= 1'b0;
        end else if (div_reg == CW'(HALF_CYC - 1)) begin
            div_reg       <= '0;
            int_level_reg <= !int_level_reg;
        end else begin
            div_reg <= div_reg + CW'(1);
        end
    end

    logic sel_internal;
    assign sel_internal = SLOW_CLOCK_ABSENT;

    // Handover waits for low phases, so the selected clock never runts
    pgscs_clock_mux u_mux (
        .clock        (CLOCK),
        .srst         (SRST),
        .sel_internal (sel_internal),
        .ext_level    (ext_level),
        .int_level    (int_level_reg),
        .slow_out     (SLOW_CLOCK_OUT)
    );

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            SLOW_CLOCK_RUNNING <= 1'b0;
        end else begin
            SLOW_CLOCK_RUNNING <= !sel_internal || supply_good;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_write_cfg;
        host_live && HOST_WR && cfg_hit(HOST_ADDR) && !trickle_rst;
    endsequence

    sequence s_supply_lost;
        !supply_good ##1 !supply_good;
    endsequence

    // Host gating
    a_no_decode_off : assert property (@(posedge CLOCK) disable iff (SRST)
        !SUPPLY_GOOD_INTERNAL |=> !HOST_ACK)
        else $error("host cycle answered without supply good");
    a_read_gated : assert property (@(posedge CLOCK) disable iff (SRST)
        !host_live |=> HOST_RDATA == pgscs_pkg::CFG_RESERVED_READ)
        else $error("read data driven while host side is off");
    a_good_follows : assert property (@(posedge CLOCK) disable iff (SRST)
        SUPPLY_GOOD_INTERNAL == $past(supply_good))
        else $error("supply good does not track main supply");
    a_host_en_pair : assert property (@(posedge CLOCK) disable iff (SRST)
        HOST_IF_ENABLE == SUPPLY_GOOD_INTERNAL)
        else $error("host enable differs from supply good");
    a_ir_timeout : assert property (@(posedge CLOCK) disable iff (SRST)
        !SUPPLY_GOOD_INTERNAL |-> !IR_TIMEOUT_ENABLE)
        else $error("ir timeout enabled without supply good");

    // Flag and standby
    a_flag_por : assert property (@(posedge CLOCK) disable iff (SRST)
        trickle_rst |=> !SLOW_CLOCK_ABSENT)
        else $error("flag not cleared by trickle reset");
    a_flag_write : assert property (@(posedge CLOCK) disable iff (SRST)
        s_write_cfg |=> SLOW_CLOCK_ABSENT == $past(HOST_WDATA[pgscs_pkg::SLOW_CLOCK_ABSENT_BIT]))
        else $error("flag write lost");
    a_flag_hold : assert property (@(posedge CLOCK) disable iff (SRST)
        !(host_live && HOST_WR && cfg_hit(HOST_ADDR)) && !trickle_rst
            |=> $stable(SLOW_CLOCK_ABSENT))
        else $error("flag changed without write or trickle reset");
    a_keep_alive : assert property (@(posedge CLOCK) disable iff (SRST)
        STANDBY_KEEP_ALIVE == !WAKE_LOGIC_RESET)
        else $error("standby logic gated by supply good");
    a_wake_reset : assert property (@(posedge CLOCK) disable iff (SRST)
        trickle_rst |=> WAKE_LOGIC_RESET)
        else $error("wake logic not reset by trickle reset");

    // Slow clock
    a_int_dead : assert property (@(posedge CLOCK) disable iff (SRST)
        s_supply_lost |-> !int_level_reg)
        else $error("internal slow clock runs on trickle");
    a_running_trickle : assert property (@(posedge CLOCK) disable iff (SRST)
        sel_internal && !supply_good |=> !SLOW_CLOCK_RUNNING)
        else $error("internal slow clock reported running on trickle");
endmodule

// ### tb.sv
// Self-checking testbench for the power-gate and slow-clock-select block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
    logic       clk = 0, srst = 1, por = 0, sup = 0, rd = 0, wr = 0, ext_on = 1;
    logic [7:0] addr = 0, wd = 0, rdat, got_rd;
    logic       ack, sgi, hen, wlr, ito, ska, absent, sout, srun, pin, flag, got_ack;
    logic [31:0] v;
    int         bad_count = 0, cmp_count = 0, seed = 32'h1892a4d1, tog, minw;
    pgscs_partner u_src (.connected(ext_on), .pin(pin));
    pgscs_top #(.HALF_CYC(4)) dut_u (
        .CLOCK(clk), .SRST(srst), .TRICKLE_POR(por), .MAIN_SUPPLY_ABOVE(sup),
        .SLOW_CLOCK_PIN(pin), .HOST_RD(rd), .HOST_WR(wr), .HOST_ADDR(addr),
        .HOST_WDATA(wd), .HOST_RDATA(rdat), .HOST_ACK(ack),
        .SUPPLY_GOOD_INTERNAL(sgi), .HOST_IF_ENABLE(hen), .WAKE_LOGIC_RESET(wlr),
        .IR_TIMEOUT_ENABLE(ito), .STANDBY_KEEP_ALIVE(ska),
        .SLOW_CLOCK_ABSENT(absent), .SLOW_CLOCK_OUT(sout), .SLOW_CLOCK_RUNNING(srun));
    initial begin
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic f);
        return (a == 8'hf0) ? {7'h00, f} : 8'h00;
    endfunction
    // Request stands over one rising edge; the one-cycle answer is read
    // at the next falling edge, while it still stands
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = w;
        rd = !w;
        addr = a;
        wd = d;
        @(negedge clk);
        got_ack = ack;
        got_rd = rdat;
        wr = 0;
        rd = 0;
    endtask
    // Toggle count and shortest settled level run, first partial run skipped
    task automatic watch();
        int run;
        logic last;
        tog = 0;
        minw = 999;
        run = 0;
        last = sout;
        repeat (300) begin
            @(posedge clk);
            #1;
            run++;
            if (sout !== last) begin
                tog++;
                if (tog > 1 && run < minw) minw = run;
                run = 0;
                last = sout;
            end
        end
    endtask
    task automatic conclude();
        $display("Compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #500000;
        bad_count++;
        conclude();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(negedge clk);
        `CHK("reset wake", 1'b1, wlr)
        `CHK("reset flag", 1'b0, absent)
        srst = 0;
        repeat (5) @(negedge clk);
        `CHK("good low", 1'b0, sgi)
        `CHK("host en low", 1'b0, hen)
        `CHK("ir timeout", 1'b0, ito)
        `CHK("keep alive", 1'b1, ska)
        bus(1, 8'hf0, 8'h01);
        `CHK("wr ignored ack", 1'b0, got_ack)
        bus(0, 8'hf0, 8'h00);
        `CHK("rd ignored ack", 1'b0, got_ack)
        `CHK("rd ignored data", 8'h00, got_rd)
        `CHK("flag untouched", 1'b0, absent)
        sup = 1;
        repeat (5) @(negedge clk);
        `CHK("good high", 1'b1, sgi)
        `CHK("host en high", 1'b1, hen)
        `CHK("ir timeout on", 1'b1, ito)
        flag = 0;
        repeat (24) begin
            v = $random(seed);
            addr = v[16] ? 8'hf0 : v[7:0];
            if (addr == 8'hf0) flag = v[8];
            bus(1, addr, v[15:8]);
            `CHK("wr ack", 1'b1, got_ack)
            bus(0, addr, 8'h00);
            `CHK("rd ack", 1'b1, got_ack)
            `CHK("rd data", exp_rd(addr, flag), got_rd)
            `CHK("flag", flag, absent)
        end
        bus(1, 8'hf0, 8'h00);
        watch();
        `CHK("ext toggles", 1'b1, tog > 10)
        `CHK("ext running", 1'b1, srun)
        fork
            watch();
            bus(1, 8'hf0, 8'h01);
        join
        `CHK("no runt", 1'b1, minw >= 3)
        ext_on = 0;
        watch();
        `CHK("int toggles", 1'b1, tog > 10)
        @(negedge clk);
        sup = 0;
        repeat (6) @(negedge clk);
        `CHK("good dropped", 1'b0, sgi)
        `CHK("ir timeout off", 1'b0, ito)
        watch();
        `CHK("int dead", 0, tog)
        `CHK("int not running", 1'b0, srun)
        `CHK("alive on trickle", 1'b1, ska)
        bus(1, 8'hf0, 8'h00);
        `CHK("trickle wr ack", 1'b0, got_ack)
        bus(0, 8'hf0, 8'h00);
        `CHK("trickle rd data", 8'h00, got_rd)
        `CHK("flag kept", 1'b1, absent)
        por = 1;
        repeat (4) @(negedge clk);
        `CHK("por wake reset", 1'b1, wlr)
        `CHK("por flag clear", 1'b0, absent)
        `CHK("por gates standby", 1'b0, ska)
        por = 0;
        ext_on = 1;
        repeat (4) @(negedge clk);
        `CHK("por released", 1'b0, wlr)
        `CHK("por clears flag", 1'b0, absent)
        watch();
        `CHK("ext on trickle", 1'b1, tog > 10)
        `CHK("ext trickle running", 1'b1, srun)
        conclude();
    end
endmodule
